/* phy_strap_pkg.sv */
// shared constants for the strap/reset device end and its host controller
package phy_strap_pkg;
	localparam int CLK_PERIOD_NS      = 8;
	localparam int RESET_MIN_NS       = 1000000;
	// least time rounds up to whole cycles
	localparam int RESET_HOLD_CYCLES  =
		(RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// completion needs strictly more than the minimum
	localparam int RESET_DONE_CYCLES  = RESET_HOLD_CYCLES + 1;
	localparam int MDC_MIN_PERIOD_NS  = 400;
	localparam int MDC_HALF_CYCLES    =
		(MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int BCR_LOOPBACK_BIT   = 14;
	localparam int BCR_AUTONEG_BIT    = 12;
	localparam int LCC_BYPASS_BIT     = 1;
	localparam logic [15:0] BCR_RESET = 16'h0000;
	localparam logic [15:0] LCC_RESET = 16'h0000;

	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STRAP  = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam int CTRL_START_BIT     = 0;
	localparam int CTRL_MDC_RUN_BIT   = 1;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0002;
	localparam logic [31:0] STRAP_RESET = 32'h0000_0000;
	localparam int STRAP_A_BIT        = 0;
	localparam int STRAP_B_BIT        = 1;
	localparam int STRAP_AN_BIT       = 2;
	localparam int STRAP_IFSEL_BIT    = 3;
	localparam int STRAP_MDIX_BIT     = 4;
	localparam int STAT_DONE_BIT      = 0;
	localparam int STAT_BUSY_BIT      = 1;
	localparam int STAT_READY_BIT     = 2;
	localparam int STAT_SCLK_LO_BIT   = 3;
endpackage

/* phy_strap_if.sv */
// strap and reset pins between host controller and transceiver end
`timescale 1ns/100ps
interface phy_strap_if;
	logic reset_n;                // active-low reset pin, host drives
	logic mdc;                    // management clock pin, host drives
	logic config_strap_a;         // first configuration strap
	logic config_strap_b;         // second configuration strap
	logic autoneg_strap;          // auto-negotiation enable strap
	logic interface_select_strap; // high for reduced or serial mii
	logic mdix_disable;           // high turns off auto crossover
	logic rst_done;               // high once device reset completed

	modport device (
		input  reset_n,
		input  mdc,
		input  config_strap_a,
		input  config_strap_b,
		input  autoneg_strap,
		input  interface_select_strap,
		input  mdix_disable,
		output rst_done
	);
	modport host (
		output reset_n,
		output mdc,
		output config_strap_a,
		output config_strap_b,
		output autoneg_strap,
		output interface_select_strap,
		output mdix_disable,
		input  rst_done
	);
endinterface

/* phy_strap_device.sv */
// transceiver end: strap capture, reset sequencing and control bits
`timescale 1ns/100ps
module phy_strap_device
	import phy_strap_pkg::*;
#(
	parameter int DONE_CYCLES = RESET_DONE_CYCLES
) (
	input  wire logic        clk,            // 125 MHz clock
	input  wire logic        arst_n,         // power-up reset, async low
	phy_strap_if.device      pins,           // strap and reset pins
	input  wire logic        bcr_we,         // write basic control reg
	input  wire logic [15:0] bcr_wdata,      // basic control write data
	input  wire logic        lcc_we,         // write line coding reg
	input  wire logic [15:0] lcc_wdata,      // line coding write data
	output logic      [15:0] bcr_rdata,      // basic control readback
	output logic      [15:0] lcc_rdata,      // line coding readback
	output logic             mlt3_bypass,    // mlt-3 coder bypassed
	output logic             loopback_en,    // loopback active
	output logic             autoneg_en,     // auto-negotiation active
	output logic      [1:0]  adv_select,     // advertised ability choice
	output logic             reduced_if,     // reduced/serial interface
	output logic             auto_mdix_en,   // auto crossover active
	output logic             ready           // registers usable
);
	localparam int CW = $clog2(DONE_CYCLES + 1);

	initial begin
		if (DONE_CYCLES < 2)
			$error("DONE_CYCLES must be at least 2");
	end

	typedef enum logic [1:0] {S_COUNT, S_WAIT_MDC, S_DONE} rst_state_t;

	// two-stage synchronisers for every input pin
	logic [6:0] meta_reg;
	logic [6:0] sync_reg;
	logic       mdc_last_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= 7'h00;
			sync_reg <= 7'h00;
		end else begin
			meta_reg <= {pins.reset_n, pins.mdc, pins.config_strap_a,
				pins.config_strap_b, pins.autoneg_strap,
				pins.interface_select_strap, pins.mdix_disable};
			sync_reg <= meta_reg;
		end
	end

	logic ext_rst_n_s;
	logic mdc_s;
	logic strap_a_s;
	logic strap_b_s;
	logic strap_an_s;
	logic strap_if_s;
	logic mdix_dis_s;
	assign {ext_rst_n_s, mdc_s, strap_a_s, strap_b_s, strap_an_s,
		strap_if_s, mdix_dis_s} = sync_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			mdc_last_reg <= 1'b0;
		else
			mdc_last_reg <= mdc_s;
	end

	logic mdc_edge;
	assign mdc_edge = mdc_s ^ mdc_last_reg;

	// reset sequencer; arst_n is the power-up reset, a low pin level returns it to S_COUNT
	rst_state_t     state_reg;
	rst_state_t     state_next;
	logic [CW-1:0]  cnt_reg;
	logic           mdc_seen_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_COUNT:
				if (cnt_reg == CW'(DONE_CYCLES - 1))
					state_next = (mdc_seen_reg || mdc_edge) ?
						S_DONE : S_WAIT_MDC;
			S_WAIT_MDC:
				if (mdc_edge)
					state_next = S_DONE;
			S_DONE:
				state_next = S_DONE;
			default:
				state_next = S_COUNT;
		endcase
		if (!ext_rst_n_s)
			state_next = S_COUNT;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			state_reg <= S_COUNT;
		else
			state_reg <= state_next;
	end

	// the count restarts while the pin is held, so a short pulse still
	// yields the full interval after its release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cnt_reg <= '0;
		else if (!ext_rst_n_s || state_reg != S_COUNT)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + CW'(1);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			mdc_seen_reg <= 1'b0;
		else if (!ext_rst_n_s)
			mdc_seen_reg <= 1'b0;
		else if (state_reg == S_COUNT && mdc_edge)
			mdc_seen_reg <= 1'b1;
	end

	logic done_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			done_reg <= 1'b0;
		else
			done_reg <= (state_next == S_DONE);
	end

	assign pins.rst_done = done_reg;
	assign ready         = done_reg;

	// straps land in the registers on the cycle reset completes
	logic load;
	assign load = (state_reg != S_DONE) && (state_next == S_DONE);

	logic [15:0] bcr_reg;
	logic [15:0] lcc_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bcr_reg <= BCR_RESET;
		end else if (state_reg != S_DONE && !load) begin
			bcr_reg <= BCR_RESET;
		end else if (load) begin
			bcr_reg <= BCR_RESET;
			bcr_reg[BCR_AUTONEG_BIT] <= strap_an_s;
			bcr_reg[BCR_LOOPBACK_BIT] <= !strap_an_s && strap_b_s;
		end else if (bcr_we) begin
			bcr_reg <= bcr_wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lcc_reg <= LCC_RESET;
		end else if (state_reg != S_DONE && !load) begin
			lcc_reg <= LCC_RESET;
		end else if (load) begin
			lcc_reg <= LCC_RESET;
			lcc_reg[LCC_BYPASS_BIT] <= !strap_an_s && strap_a_s;
		end else if (lcc_we) begin
			lcc_reg <= lcc_wdata;
		end
	end

	// mode pins sampled at completion, as a real strap is
	logic [1:0] adv_reg;
	logic       if_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			adv_reg <= 2'h0;
			if_reg  <= 1'b0;
		end else if (load) begin
			adv_reg <= {strap_b_s, strap_a_s};
			if_reg  <= strap_if_s;
		end
	end

	// crossover pin stays live; high taken as the disabling level
	logic mdix_en_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			mdix_en_reg <= 1'b0;
		else
			mdix_en_reg <= done_reg && !mdix_dis_s;
	end

	assign bcr_rdata    = bcr_reg;
	assign lcc_rdata    = lcc_reg;
	assign autoneg_en   = bcr_reg[BCR_AUTONEG_BIT];
	assign mlt3_bypass  = lcc_reg[LCC_BYPASS_BIT];
	assign loopback_en  = bcr_reg[BCR_LOOPBACK_BIT];
	assign adv_select   = bcr_reg[BCR_AUTONEG_BIT] ? adv_reg : 2'h0;
	assign reduced_if   = if_reg;
	assign auto_mdix_en = mdix_en_reg;
endmodule

/* phy_strap_host.sv */
// host end: apb registers driving straps, reset pin and management clock
`timescale 1ns/100ps
module phy_strap_host
	import phy_strap_pkg::*;
#(
	parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
	parameter int MDC_HALF    = MDC_HALF_CYCLES
) (
	input  wire logic        clk,      // 125 MHz clock
	input  wire logic        arst_n,   // async reset, active low
	phy_strap_if.host        pins,     // strap and reset pins
	input  wire logic        psel,     // apb select
	input  wire logic        penable,  // apb access phase
	input  wire logic        pwrite,   // apb write
	input  wire logic [11:0] paddr,    // apb byte address
	input  wire logic [31:0] pwdata,   // apb write data
	output logic      [31:0] prdata,   // apb read data
	output logic             pready,   // apb ready
	output logic             pslverr   // apb error, unmapped address
);
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam int MW = $clog2(MDC_HALF + 1);

	initial begin
		if (HOLD_CYCLES < 1 || MDC_HALF < 1)
			$error("HOLD_CYCLES and MDC_HALF must be at least 1");
	end

	typedef enum logic [1:0] {H_HOLD, H_WAIT, H_IDLE} host_state_t;

	function automatic logic mapped(input logic [11:0] a);
		return a == OFS_CTRL || a == OFS_STRAP || a == OFS_STATUS;
	endfunction

	logic [31:0] ctrl_reg;
	logic [31:0] strap_reg;
	logic        wr_ok;
	assign wr_ok  = psel && penable && pwrite && mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);

	logic start;
	assign start = wr_ok && paddr == OFS_CTRL && pwdata[CTRL_START_BIT];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg  <= CTRL_RESET;
			strap_reg <= STRAP_RESET;
		end else if (wr_ok) begin
			if (paddr == OFS_CTRL)
				ctrl_reg <= pwdata & 32'h0000_0002;
			if (paddr == OFS_STRAP)
				strap_reg <= pwdata & 32'h0000_001f;
		end
	end

	// done pin crosses from the device side
	logic [1:0] done_sync_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			done_sync_reg <= 2'h0;
		else
			done_sync_reg <= {done_sync_reg[0], pins.rst_done};
	end

	host_state_t   state_reg;
	logic [HW-1:0] hold_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= H_HOLD;
			hold_reg  <= '0;
		end else if (start) begin
			state_reg <= H_HOLD;
			hold_reg  <= '0;
		end else begin
			case (state_reg)
				H_HOLD:
					if (hold_reg == HW'(HOLD_CYCLES - 1))
						state_reg <= H_WAIT;
					else
						hold_reg <= hold_reg + HW'(1);
				H_WAIT:
					if (done_sync_reg[1])
						state_reg <= H_IDLE;
				H_IDLE:
					state_reg <= H_IDLE;
				default:
					state_reg <= H_HOLD;
			endcase
		end
	end

	// mdc runs at the management maximum; disabling it stalls completion
	logic [MW-1:0] mdc_cnt_reg;
	logic          mdc_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mdc_cnt_reg <= '0;
			mdc_reg     <= 1'b0;
		end else if (!ctrl_reg[CTRL_MDC_RUN_BIT]) begin
			mdc_cnt_reg <= '0;
		end else if (mdc_cnt_reg == MW'(MDC_HALF - 1)) begin
			mdc_cnt_reg <= '0;
			mdc_reg     <= !mdc_reg;
		end else begin
			mdc_cnt_reg <= mdc_cnt_reg + MW'(1);
		end
	end

	logic rst_pin_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rst_pin_reg <= 1'b0;
		else
			rst_pin_reg <= !(start || (state_reg == H_HOLD &&
				hold_reg != HW'(HOLD_CYCLES - 1)));
	end

	assign pins.reset_n = rst_pin_reg;
	assign pins.mdc     = mdc_reg;
	assign pins.config_strap_a         = strap_reg[STRAP_A_BIT];
	assign pins.config_strap_b         = strap_reg[STRAP_B_BIT];
	assign pins.autoneg_strap          = strap_reg[STRAP_AN_BIT];
	assign pins.interface_select_strap = strap_reg[STRAP_IFSEL_BIT];
	assign pins.mdix_disable           = strap_reg[STRAP_MDIX_BIT];

	logic [31:0] status;
	always_comb begin
		status = 32'h0;
		status[STAT_DONE_BIT]  = done_sync_reg[1];
		status[STAT_BUSY_BIT]  = state_reg != H_IDLE;
		status[STAT_READY_BIT] = state_reg == H_IDLE;
		// sysclk needed: 0 none (mii), 1 required (reduced/serial)
		status[STAT_SCLK_LO_BIT] = strap_reg[STRAP_IFSEL_BIT];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CTRL:   prdata <= ctrl_reg;
				OFS_STRAP:  prdata <= strap_reg;
				OFS_STATUS: prdata <= status;
				default:    prdata <= 32'h0;
			endcase
		end
	end
endmodule

/* phy_strap_config_and_reset_asserts.sv */
// pin-level checks on the strap and reset link between both ends
`timescale 1ns/100ps
module phy_strap_config_and_reset_asserts #(
	parameter int HOLD_CYCLES = 20,
	parameter int DONE_CYCLES = 21,
	parameter int MDC_HALF    = 25
) (
	input wire logic clk,      // system clock
	input wire logic arst_n,   // power-up reset
	input wire logic reset_n,  // reset pin
	input wire logic mdc,      // management clock pin
	input wire logic rst_done  // reset done pin
);
	int unsigned lo_cnt   = 0;
	int unsigned hi_cnt   = 0;
	int unsigned mdc_cnt  = 0;
	logic        mdc_q    = 1'b0;
	logic        mdc_seen = 1'b0;
	// counters run through arst so power-up low time counts too
	always_ff @(posedge clk) begin
		lo_cnt <= reset_n ? 0 : lo_cnt + 1;
		hi_cnt <= !reset_n ? 0 : (hi_cnt < 1000 ? hi_cnt + 1 : hi_cnt);
	end
	always_ff @(posedge clk) begin
		mdc_q    <= mdc;
		mdc_cnt  <= (mdc != mdc_q) ? 0 :
			(mdc_cnt < 1000 ? mdc_cnt + 1 : 1000);
		mdc_seen <= !reset_n ? 1'b0 : (mdc_seen | (mdc != mdc_q));
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_power_up_low: assert property ($rose(arst_n) |-> !rst_done)
		else $error("done high at power-up");
	chk_host_hold: assert property (
		$rose(reset_n) |-> lo_cnt >= HOLD_CYCLES)
		else $error("reset pin held too short");
	chk_done_wait: assert property (
		$rose(rst_done) |-> hi_cnt > DONE_CYCLES)
		else $error("done rose too early");
	chk_done_mdc: assert property ($rose(rst_done) |-> mdc_seen)
		else $error("done without mdc transition");
	chk_done_timely: assert property (
		hi_cnt == DONE_CYCLES + 40 |-> rst_done)
		else $error("done never rose");
	chk_fall_on_reset: assert property (
		$fell(reset_n) |-> ##[1:4] !rst_done)
		else $error("done stayed high in reset");
	chk_done_stands: assert property ($fell(rst_done) |-> !reset_n)
		else $error("done dropped without reset");
	chk_mdc_rate: assert property (
		$changed(mdc) |-> mdc_cnt >= MDC_HALF - 1)
		else $error("mdc too fast");
endmodule

/* phy_strap_config_and_reset_test.sv */
// self-checking bench: host drives straps and reset of the device end
`timescale 1ns/100ps
module phy_strap_config_and_reset_test;
	import phy_strap_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, bcr_we = 1'b0, lcc_we = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, mlt3_bypass, loopback_en, autoneg_en;
	logic reduced_if, auto_mdix_en, ready;
	logic [15:0] bcr_wdata = 16'h0, lcc_wdata = 16'h0, bcr_rdata, lcc_rdata;
	logic [1:0] adv_select;
	int fail_count = 0, checks = 0;
	phy_strap_if pins_if();
	phy_strap_device #(.DONE_CYCLES(21)) u_phy_strap_device (.clk(clk),
		.arst_n(arst_n), .pins(pins_if), .bcr_we(bcr_we),
		.bcr_wdata(bcr_wdata), .lcc_we(lcc_we), .lcc_wdata(lcc_wdata),
		.bcr_rdata(bcr_rdata), .lcc_rdata(lcc_rdata),
		.mlt3_bypass(mlt3_bypass), .loopback_en(loopback_en),
		.autoneg_en(autoneg_en), .adv_select(adv_select),
		.reduced_if(reduced_if), .auto_mdix_en(auto_mdix_en), .ready(ready));
	phy_strap_host #(.HOLD_CYCLES(20), .MDC_HALF(MDC_HALF_CYCLES))
		u_phy_strap_host (.clk(clk), .arst_n(arst_n), .pins(pins_if),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	phy_strap_config_and_reset_asserts #(.HOLD_CYCLES(20), .DONE_CYCLES(21),
		.MDC_HALF(MDC_HALF_CYCLES)) u_phy_strap_config_and_reset_asserts (
		.clk(clk), .arst_n(arst_n), .reset_n(pins_if.reset_n),
		.mdc(pins_if.mdc), .rst_done(pins_if.rst_done));
	always #4 clk = ~clk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// holds the request until pready is sampled high, wait has no bound of its own
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a stuck wait
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wait_ready(input logic v);
		for (int n = 0; n < 300 && ready !== v; n++) @(posedge clk);
		check(ready, v);
	endtask
	task automatic check_outs(input logic [4:0] s);
		logic an;
		an = s[2];
		// crossover enable is registered one cycle behind done
		@(posedge clk);
		check(bcr_rdata, {1'b0, ~an & s[1], 1'b0, an, 12'h0});
		check(lcc_rdata, {14'h0, ~an & s[0], 1'b0});
		check({mlt3_bypass, loopback_en, autoneg_en},
			{~an & s[0], ~an & s[1], an});
		check(adv_select, an ? s[1:0] : 2'b00);
		check({reduced_if, auto_mdix_en}, {s[3], ~s[4]});
		repeat (4) @(posedge clk);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(r, {28'h0, s[3], 3'b101});
		apb(1'b0, OFS_CTRL, 32'h0);
		check(r, 32'h0000_0002);
	endtask
	initial begin
		#160000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		wait_ready(1'b1);
		check_outs(5'h00);
		// every strap combination, each through a full host-started reset
		for (int i = 0; i < 32; i++) begin
			apb(1'b1, OFS_STRAP, i);
			apb(1'b1, OFS_CTRL, 32'h0000_0003);
			wait_ready(1'b0);
			check(pins_if.rst_done, 1'b0);
			wait_ready(1'b1);
			check_outs(i[4:0]);
		end
		apb(1'b0, 12'h00c, 32'h0);
		check(r, 32'h0);
		check(e, 1'b1);
		apb(1'b1, 12'h010, 32'hffff_ffff);
		check(e, 1'b1);
		@(posedge clk);
		bcr_we <= 1'b1; bcr_wdata <= 16'h4000;
		lcc_we <= 1'b1; lcc_wdata <= 16'h0002;
		@(posedge clk);
		bcr_we <= 1'b0; lcc_we <= 1'b0;
		repeat (2) @(posedge clk);
		check({loopback_en, mlt3_bypass, autoneg_en}, 3'b110);
		report_and_stop();
	end
endmodule
